// file: hdl/dac_input_and_power_modes.v
// DAC input pipeline, power modes and AXI4-Lite register slave
//
// Behaviour
// - Reference select low: internal 1.2V reference out
// - Standby: reference and amplifier on, array off
// - Enable high leaves standby, 50us wake
// - Power-down select high forces shutdown
// - Leave shutdown: select low, enable high, 50us
// - After wake, output resumes pre-standby value
// - Low power: current output hi-Z, voltage grounded
// - Each rising edge latches eight data bits
// - Latched word reaches output four clocks later (sync, FIFO, latch) when active and the FIFO is empty
`timescale 1ns/1ps
`include "dac_ctrl_regs.vh"
module dac_input_and_power_modes #(
	parameter DATA_W = 8,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3,
	parameter WAKE_CYCLES = `WAKE_CYCLES,
	parameter VOLTAGE_VARIANT = 0
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Mode pins and reference strap
	input wire power_down_select,
	input wire converter_enable,
	input wire ref_select_n,
	// Parallel data pins and host stream handshake
	input wire [DATA_W-1:0] data_pins,
	input wire data_valid,
	output wire data_ready,
	// Converter-facing outputs
	output reg [DATA_W-1:0] dac_code,
	output reg array_enable,
	output reg output_drive_oe,
	output reg output_ground,
	output reg ref_internal_en,
	output reg ref_pin_drive_oe,
	output reg amp_enable,
	output reg output_settled,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam ST_ACTIVE = 4'b0001;
	localparam ST_STANDBY = 4'b0010;
	localparam ST_SHUTDOWN = 4'b0100;
	localparam ST_WAKE = 4'b1000;
	localparam [1:0] RESP_OKAY = 2'b00;
	localparam [1:0] RESP_SLVERR = 2'b10;

	// Pin synchronisers
	reg [1:0] pd_sync;
	reg [1:0] en_sync;
	reg [1:0] ref_sync;
	reg [DATA_W-1:0] data_meta;
	reg [DATA_W-1:0] data_sync;
	reg [1:0] dv_sync;
	reg [31:0] ctrl;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [31:0] wake_cnt;
	reg [DATA_W-1:0] input_latch;
	reg [DATA_W-1:0] held_code;
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire pd_eff;
	wire en_eff;
	wire fifo_valid;
	wire [DATA_W-1:0] fifo_data;
	wire fifo_full;
	wire fifo_empty;
	wire fifo_pop;
	wire sw_push;
	wire pin_push;
	wire do_write;
	wire running;

	function [31:0] merge_strb;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer i;
		begin
			merge_strb = old_val;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pd_sync <= 2'b00;
			en_sync <= 2'b00;
			ref_sync <= 2'b00;
			data_meta <= {DATA_W{1'b0}};
			data_sync <= {DATA_W{1'b0}};
			dv_sync <= 2'b00;
		end else begin
			pd_sync <= {pd_sync[0], power_down_select};
			en_sync <= {en_sync[0], converter_enable};
			ref_sync <= {ref_sync[0], ref_select_n};
			data_meta <= data_pins;
			data_sync <= data_meta;
			dv_sync <= {dv_sync[0], data_valid};
		end
	end

	// Pins or software may request power-down; either forces it
	assign pd_eff = pd_sync[1] | ctrl[`CTRL_PD_SEL_BIT];
	assign en_eff = en_sync[1] | ctrl[`CTRL_CONV_EN_BIT];

	always @* begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (pd_eff)
					next_state = ST_SHUTDOWN;
				else if (!en_eff)
					next_state = ST_STANDBY;
			end
			ST_STANDBY, ST_SHUTDOWN: begin
				if (pd_eff)
					next_state = ST_SHUTDOWN;
				else if (en_eff)
					next_state = ST_WAKE;
				else
					next_state = ST_STANDBY;
			end
			ST_WAKE: begin
				if (pd_eff)
					next_state = ST_SHUTDOWN;
				else if (!en_eff)
					next_state = ST_STANDBY;
				else if (wake_cnt == 32'h0000_0000)
					next_state = ST_ACTIVE;
			end
			default: next_state = ST_SHUTDOWN;
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_SHUTDOWN;
			wake_cnt <= 32'h0000_0000;
		end else begin
			state <= next_state;
			if (next_state == ST_WAKE && state != ST_WAKE)
				wake_cnt <= WAKE_CYCLES - 1;
			else if (state == ST_WAKE && wake_cnt != 32'h0000_0000)
				wake_cnt <= wake_cnt - 1;
		end
	end

	// Pin samples enter the FIFO whenever synchronised data_valid is high and the FIFO is not full, ahead of a DATA write
	assign pin_push = dv_sync[1];
	assign running = (state == ST_ACTIVE);
	// Drain paces at one word per clock, stalls outside active mode
	assign fifo_pop = running && fifo_valid;

	sample_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(pin_push | sw_push),
		.in_ready(data_ready),
		.in_data(sw_push ? w_data[DATA_W-1:0] : data_sync),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			input_latch <= {DATA_W{1'b0}};
			held_code <= {DATA_W{1'b0}};
			dac_code <= {DATA_W{1'b0}};
			array_enable <= 1'b0;
			output_drive_oe <= 1'b0;
			output_ground <= 1'b0;
			ref_internal_en <= 1'b0;
			ref_pin_drive_oe <= 1'b0;
			amp_enable <= 1'b0;
			output_settled <= 1'b0;
		end else begin
			if (fifo_pop)
				input_latch <= fifo_data;
			if (running)
				held_code <= input_latch;
			// Code stays frozen in low power so wake resumes it
			dac_code <= running ? input_latch : held_code;
			array_enable <= running;
			output_drive_oe <= running || (VOLTAGE_VARIANT != 0);
			output_ground <= !running && (VOLTAGE_VARIANT != 0);
			ref_internal_en <= !ref_sync[1] && (state != ST_SHUTDOWN);
			// Internal reference drives the pin when the strap is low, outside shutdown
			ref_pin_drive_oe <= !ref_sync[1] && (state != ST_SHUTDOWN);
			amp_enable <= (state != ST_SHUTDOWN);
			output_settled <= running;
		end
	end

	// AXI4-Lite write path
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign sw_push = do_write && (aw_addr == `REG_DATA) && !fifo_full && !pin_push;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ctrl <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// DATA write waits while the FIFO is full or a pin sample is pushed
			if (do_write && (aw_addr != `REG_DATA || sw_push)) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
				case (aw_addr)
					`REG_CTRL: ctrl <= merge_strb(ctrl, w_data, w_strb) & 32'h0000_0003;
					`REG_DATA: ;
					`REG_STATUS, `REG_LATCH: s_axi_bresp <= RESP_SLVERR;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	// AXI4-Lite read path
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				case (s_axi_araddr)
					`REG_CTRL: s_axi_rdata <= ctrl;
					`REG_STATUS: begin
						s_axi_rdata[`ST_MODE_LSB +: 3] <= state[2:0];
						s_axi_rdata[`ST_READY_BIT] <= output_settled;
						s_axi_rdata[`ST_REF_INT_BIT] <= !ref_sync[1];
						s_axi_rdata[`ST_FULL_BIT] <= fifo_full;
						s_axi_rdata[`ST_EMPTY_BIT] <= fifo_empty;
					end
					`REG_DATA: s_axi_rdata[DATA_W-1:0] <= input_latch;
					`REG_LATCH: s_axi_rdata[DATA_W-1:0] <= dac_code;
					default: s_axi_rresp <= RESP_SLVERR;
				endcase
			end
		end
	end
endmodule // dac_input_and_power_modes

// file: hdl/dac_ctrl_regs.vh
// Register offsets, fields, reset values and timing counts for the DAC control block
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08
`define REG_LATCH 8'h0C
`define CTRL_CONV_EN_BIT 0
`define CTRL_PD_SEL_BIT 1
`define CTRL_RESET 32'h0000_0000
`define ST_MODE_LSB 0
`define ST_READY_BIT 3
`define ST_REF_INT_BIT 4
`define ST_FULL_BIT 5
`define ST_EMPTY_BIT 6
`define WAKE_TIME_US 50
`define CLK_MHZ 40
`define WAKE_CYCLES (`WAKE_TIME_US * `CLK_MHZ)
`endif

// file: hdl/sample_fifo.v
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	// Status
	output wire full,
	output wire empty
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	assign full = (count == DEPTH[AW:0]);
	assign empty = (count == {(AW+1){1'b0}});
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	always @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // sample_fifo

// file: verif/dac_modes_props.sv
// Checker for power modes, code hold and register answers of the DAC block
`timescale 1ns/1ps
module dac_modes_props #(
	parameter WAKE_CYCLES = 2000
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Mode pins
	input wire power_down_select,
	input wire converter_enable,
	// Converter side
	input wire [7:0] dac_code,
	input wire array_enable,
	input wire output_drive_oe,
	input wire ref_internal_en,
	input wire ref_pin_drive_oe,
	input wire amp_enable,
	// Register bus answers
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata
);
	int wake_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Cycles the pins have asked for power-up; software bits are not seen here
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			wake_cnt <= 0;
		else if (converter_enable && !power_down_select)
			wake_cnt <= wake_cnt + 1;
		else
			wake_cnt <= 0;
	end
	a_ref_pin_same: assert property (ref_pin_drive_oe == ref_internal_en)
		else $error("reference pin drive differs from reference enable");
	a_ref_needs_amp: assert property (ref_internal_en |-> amp_enable)
		else $error("reference on while amplifier off");
	a_array_needs_amp: assert property (array_enable |-> amp_enable)
		else $error("array on while amplifier off");
	a_drive_when_on: assert property (output_drive_oe == array_enable)
		else $error("output driven outside active state");
	a_pd_shutdown: assert property (power_down_select [*6] |-> !amp_enable && !array_enable)
		else $error("select high did not shut down");
	a_wake_floor: assert property ($rose(array_enable) |-> wake_cnt >= WAKE_CYCLES)
		else $error("array on before wake time");
	a_wake_ceiling: assert property (wake_cnt == WAKE_CYCLES + 10 |-> array_enable)
		else $error("array still off after wake time");
	a_code_hold: assert property (!array_enable && !$past(array_enable) && !$past(array_enable, 2)
		|-> $stable(dac_code))
		else $error("code moved outside active state");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	c_wake: cover property ($rose(array_enable));
	c_shut: cover property (power_down_select [*6]);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // dac_modes_props
bind dac_input_and_power_modes dac_modes_props #(.WAKE_CYCLES(WAKE_CYCLES)) props_u (.clk, .nrst,
	.power_down_select, .converter_enable, .dac_code, .array_enable, .output_drive_oe,
	.ref_internal_en, .ref_pin_drive_oe, .amp_enable, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// file: verif/host_pins.sv
// Host logic model driving the data and mode pins
`timescale 1ns/1ps
module host_pins (
	// Clock
	input wire clk,
	// Pins to the block
	output logic power_down_select,
	output logic converter_enable,
	output logic ref_select_n,
	output logic [7:0] data_pins,
	output logic data_valid
);
	initial begin
		power_down_select = 1'h1;
		converter_enable = 1'h0;
		ref_select_n = 1'h0;
		data_pins = 8'h00;
		data_valid = 1'h0;
	end
	// Mode pins stay put until moved again, so wake is never disturbed
	task set_mode(input logic pd, input logic en, input logic rs);
		@(posedge clk);
		power_down_select <= pd;
		converter_enable <= en;
		ref_select_n <= rs;
	endtask
	// Idle pins show the inverse, so a stale sample never looks right
	task send(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			data_pins <= 8'(b + i);
			data_valid <= 1'h1;
		end
		@(posedge clk);
		data_pins <= ~8'(b + n - 1);
		data_valid <= 1'h0;
	endtask
endmodule // host_pins

// file: verif/dac_input_and_power_modes_tb_top.sv
// Bench for the DAC input pipeline, power modes and registers
`timescale 1ns/1ps
`include "dac_ctrl_regs.vh"
module dac_input_and_power_modes_tb_top;
	logic clk = 0;
	logic nrst = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire power_down_select, converter_enable, ref_select_n, data_valid, data_ready;
	wire [7:0] data_pins, dac_code;
	wire array_enable, output_drive_oe, output_ground, ref_internal_en, ref_pin_drive_oe;
	wire amp_enable, output_settled;
	int n_errors = 0, checks = 0, cyc = 0, n;
	logic [31:0] rd;
	logic [1:0] rs;
	initial forever #12.5 clk = ~clk;
	host_pins host_u (.clk, .power_down_select, .converter_enable, .ref_select_n, .data_pins,
		.data_valid);
	dac_input_and_power_modes #(.WAKE_CYCLES(20)) dut_u (.clk, .nrst, .power_down_select,
		.converter_enable, .ref_select_n, .data_pins, .data_valid, .data_ready, .dac_code,
		.array_enable, .output_drive_oe, .output_ground, .ref_internal_en, .ref_pin_drive_oe,
		.amp_enable, .output_settled, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	task end_of_test;
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// Late ready keeps the answer waiting, so the hold checks see a stall
	task wr_slow(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do @(posedge clk); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		repeat (2) @(posedge clk);
		s_axi_bready <= 1;
		do @(posedge clk); while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rdr_slow(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 0;
		repeat (2) @(posedge clk);
		s_axi_rready <= 1;
		do @(posedge clk); while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		s_axi_rready <= 0;
	endtask
	task wake;
		n = 0;
		while (array_enable !== 1'h1 && n < 100) begin
			@(posedge clk);
			n++;
		end
	endtask
	task t_reset;
		rdr(`REG_CTRL);
		chk("ctrl", `CTRL_RESET, rd);
		rdr(`REG_STATUS);
		chk("mode", 3'h4, rd[2:0]);
	endtask
	task t_wake;
		host_u.set_mode(0, 1, 0);
		wake;
		chk("wake", 1'h1, n >= 20 && n <= 30 && array_enable === 1'h1);
		chk("settled", 1'h1, output_settled);
		chk("ref", 1'h1, ref_internal_en & ref_pin_drive_oe);
	endtask
	task t_pipe;
		host_u.send(8'hA5, 2);
		n = 0;
		while (dac_code !== 8'hA5 && n < 20) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		chk("code", 8'hA6, dac_code);
	endtask
	task t_standby;
		host_u.set_mode(0, 0, 0);
		repeat (6) @(posedge clk);
		chk("array", 1'h0, array_enable);
		chk("amp", 1'h1, amp_enable & ref_internal_en);
		chk("out", 2'h0, {output_drive_oe, output_ground});
		host_u.send(8'h10, 10);
		repeat (4) @(posedge clk);
		chk("ready", 1'h0, data_ready);
		rdr(`REG_STATUS);
		chk("full", 1'h1, rd[`ST_FULL_BIT]);
		host_u.set_mode(0, 1, 0);
		repeat (10) @(posedge clk);
		chk("hold", 8'hA6, dac_code);
		wake;
		chk("wake2", 1'h1, n >= 10 && n <= 20 && array_enable === 1'h1);
		repeat (20) @(posedge clk);
		chk("drain", 8'h17, dac_code);
		rdr(`REG_STATUS);
		chk("empty", 1'h1, rd[`ST_EMPTY_BIT]);
	endtask
	task t_shut;
		host_u.set_mode(1, 1, 1);
		repeat (6) @(posedge clk);
		chk("shut", 1'h0, amp_enable | ref_internal_en | array_enable);
		host_u.set_mode(0, 1, 1);
		wake;
		chk("wake3", 1'h1, n >= 20 && n <= 30 && array_enable === 1'h1);
		chk("resume", 8'h17, dac_code);
		chk("ext", 1'h0, ref_internal_en | ref_pin_drive_oe);
	endtask
	task t_regs;
		wr(`REG_STATUS, 32'h0000_0000);
		chk("ro", 2'h2, rs);
		rdr(8'h10);
		chk("unmap data", 32'h0000_0000, rd);
		chk("unmap resp", 2'h2, rs);
		wr(`REG_DATA, 32'h0000_00C3);
		repeat (8) @(posedge clk);
		rdr(`REG_LATCH);
		chk("latch", 32'h0000_00C3, rd);
		wr_slow(`REG_CTRL, 32'h0000_0002);
		chk("ctrl resp", 2'h0, rs);
		repeat (6) @(posedge clk);
		chk("swpd", 1'h0, amp_enable);
		rdr_slow(`REG_CTRL);
		chk("ctrl back", 32'h0000_0002, rd);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1;
		t_reset;
		t_wake;
		t_pipe;
		t_standby;
		t_shut;
		t_regs;
		end_of_test;
	end
endmodule // dac_input_and_power_modes_tb_top
